// File: hw/comparator_vref_control.v
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "cmp_vref_map.vh"
// Overview of operation
// RULE_01 - results drive pins and register bits
// RULE_02 - bit 7 cmp2 result, invert flips
// RULE_03 - bit 6 cmp1 result, invert flips
// RULE_04 - bits 5,4 invert outputs, reset 0
// RULE_05 - mode 110: swap picks AN3/AN2 inputs
// RULE_06 - mode field bits 2:0, resets 111
// RULE_07 - power bit enables ladder, reset 0
// RULE_08 - pin drive overrides AN2 direction bit
// RULE_09 - bit 5 selects ladder range
// RULE_10 - range set: level/24 of span
// RULE_11 - range clear: span/4 plus level/32
// RULE_12 - bit 4 picks external or rail supply
// RULE_13 - level code bits 3:0, reset 0
// RULE_14 - comparator results synchronised before reading
// RULE_15 - swap bit inert outside mode 110
module comparator_vref_control (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire [1:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  input  wire       cmp1_raw,
  input  wire       cmp2_raw,
  input  wire       porta_pin2_direction,
  output reg        cmp1_pin,
  output reg        cmp2_pin,
  output reg  [2:0] cmp_mode_sel,
  output reg        cmp1_neg_an3,
  output reg        cmp2_neg_an2,
  output reg        ladder_power_on,
  output reg        ladder_supply_sel,
  output reg        ladder_range_sel,
  output reg  [3:0] ladder_level_code,
  output reg        an2_ladder_connect,
  output reg        an2_pin_input,
  output reg  [5:0] ladder_tap_num,
  output reg  [5:0] ladder_tap_den
);
  reg        cmp2_invert_q;
  reg        cmp1_invert_q;
  reg        neg_input_swap_q;
  reg  [2:0] mode_q;
  reg  [7:0] ladder_q;
  wire       cmp1_sync;
  wire       cmp2_sync;
  wire       cmp1_result;
  wire       cmp2_result;
  wire [5:0] tap_num_w;
  wire [5:0] tap_den_w;
  wire       swap_active;

  // RULE_14 two-flop sync
  sync2 u_sync1 (
    .core_clk (core_clk),
    .nrst     (nrst),
    .din      (cmp1_raw),
    .dout     (cmp1_sync)
  );
  sync2 u_sync2 (
    .core_clk (core_clk),
    .nrst     (nrst),
    .din      (cmp2_raw),
    .dout     (cmp2_sync)
  );

  // RULE_10 RULE_11 tap ratio
  ladder_tap u_tap (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .range_sel (ladder_q[`LADDER_RANGE_BIT]),
    .level     (ladder_q[`LEVEL_MSB:`LEVEL_LSB]),
    .tap_num   (tap_num_w),
    .tap_den   (tap_den_w)
  );

  // RULE_02 RULE_03 invert applied
  assign cmp2_result = cmp2_sync ^ cmp2_invert_q;
  assign cmp1_result = cmp1_sync ^ cmp1_invert_q;
  // RULE_05 RULE_15 swap gated by mode
  assign swap_active = (mode_q == `MODE_SWAPPABLE) & neg_input_swap_q;

  // register writes
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp2_invert_q    <= 1'b0;
      cmp1_invert_q    <= 1'b0;
      neg_input_swap_q <= 1'b0;
      mode_q           <= `MODE_RST;
      ladder_q         <= `LADDER_RST;
    end else if (wr_stb) begin
      if (addr == `ADDR_CMP_CTRL) begin
        // RULE_04 invert bits
        cmp2_invert_q    <= wdata[`CMP2_INVERT_BIT];
        cmp1_invert_q    <= wdata[`CMP1_INVERT_BIT];
        neg_input_swap_q <= wdata[`NEG_SWAP_BIT];
        // RULE_06 mode field
        mode_q           <= wdata[`MODE_MSB:`MODE_LSB];
      end else if (addr == `ADDR_LADDER_CTRL) begin
        // RULE_13 level and controls
        ladder_q <= wdata;
      end
    end
  end

  // read data one cycle later; unmapped reads zero
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd_stb && addr == `ADDR_CMP_CTRL) begin
      // RULE_01 results readable
      rdata <= {cmp2_result, cmp1_result, cmp2_invert_q, cmp1_invert_q,
                neg_input_swap_q, mode_q};
    end else if (rd_stb && addr == `ADDR_LADDER_CTRL) begin
      rdata <= ladder_q;
    end else begin
      rdata <= 8'h00;
    end
  end

  // registered outputs; one cycle behind the registers, tap num/den two cycles behind ladder_q
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp1_pin           <= 1'b0;
      cmp2_pin           <= 1'b0;
      cmp_mode_sel       <= `MODE_RST;
      cmp1_neg_an3       <= 1'b0;
      cmp2_neg_an2       <= 1'b0;
      ladder_power_on    <= 1'b0;
      ladder_supply_sel  <= 1'b0;
      ladder_range_sel   <= 1'b0;
      ladder_level_code  <= 4'h0;
      an2_ladder_connect <= 1'b0;
      an2_pin_input      <= 1'b1;
      ladder_tap_num     <= `TAP_NUM_RST;
      ladder_tap_den     <= `TAP_DEN_RST;
    end else begin
      // RULE_01 pin outputs
      cmp1_pin           <= cmp1_result;
      cmp2_pin           <= cmp2_result;
      cmp_mode_sel       <= mode_q;
      // RULE_05 negative input routing
      cmp1_neg_an3       <= swap_active;
      cmp2_neg_an2       <= swap_active;
      // RULE_07 ladder power
      ladder_power_on    <= ladder_q[`LADDER_POWER_BIT];
      // RULE_12 supply select
      ladder_supply_sel  <= ladder_q[`LADDER_SUPPLY_BIT];
      // RULE_09 range select
      ladder_range_sel   <= ladder_q[`LADDER_RANGE_BIT];
      ladder_level_code  <= ladder_q[`LEVEL_MSB:`LEVEL_LSB];
      // RULE_08 drive overrides direction
      an2_ladder_connect <= ladder_q[`LADDER_PIN_BIT];
      an2_pin_input      <= porta_pin2_direction & ~ladder_q[`LADDER_PIN_BIT];
      ladder_tap_num     <= tap_num_w;
      ladder_tap_den     <= tap_den_w;
    end
  end
endmodule

// File: hw/ladder_tap.v
`timescale 1ns/10ps
`include "cmp_vref_map.vh"
module ladder_tap (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       range_sel,
  input  wire [3:0] level,
  output reg  [5:0] tap_num,
  output reg  [5:0] tap_den
);
  // tap = numerator/denominator of the supply span
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tap_num <= `TAP_NUM_RST;
      tap_den <= `TAP_DEN_RST;
    end else if (range_sel) begin
      // RULE_10 level over 24
      tap_num <= {2'b00, level};
      tap_den <= `RANGE_HI_DEN;
    end else begin
      // RULE_11 quarter plus level/32
      tap_num <= {2'b00, level} + `RANGE_LO_BASE;
      tap_den <= `RANGE_LO_DEN;
    end
  end
endmodule

// File: hw/sync2.v
`timescale 1ns/10ps
module sync2 (
  input  wire core_clk,
  input  wire nrst,
  input  wire din,
  output reg  dout
);
  reg meta_q;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// File: inc/cmp_vref_map.vh
`ifndef CMP_VREF_MAP_VH
`define CMP_VREF_MAP_VH

// register indices on the plain port
`define ADDR_CMP_CTRL         2'h0
`define ADDR_LADDER_CTRL      2'h1

// comparator_control fields
`define CMP2_RESULT_BIT       7
`define CMP1_RESULT_BIT       6
`define CMP2_INVERT_BIT       5
`define CMP1_INVERT_BIT       4
`define NEG_SWAP_BIT          3
`define MODE_MSB              2
`define MODE_LSB              0
`define MODE_RST              3'h7
`define MODE_SWAPPABLE        3'h6

// reference_ladder_control fields
`define LADDER_POWER_BIT      7
`define LADDER_PIN_BIT        6
`define LADDER_RANGE_BIT      5
`define LADDER_SUPPLY_BIT     4
`define LEVEL_MSB             3
`define LEVEL_LSB             0
`define LADDER_RST            8'h00

// ladder ratios: high range level/24, low range 8/32 + level/32
`define RANGE_HI_DEN          6'h18
`define RANGE_LO_DEN          6'h20
`define RANGE_LO_BASE         6'h08
// reset tap: low range, level 0
`define TAP_NUM_RST           6'h08
`define TAP_DEN_RST           6'h20

`endif

// File: verif/analog_cmp_model.sv
`timescale 1ns/10ps
module analog_cmp_model (
  input  wire [7:0] vin1_pos,
  input  wire [7:0] vin2_pos,
  input  wire [7:0] vin_neg,
  output wire       cmp1_raw,
  output wire       cmp2_raw
);
  // high while positive side is above
  assign cmp1_raw = vin1_pos > vin_neg;
  assign cmp2_raw = vin2_pos > vin_neg;
endmodule

// File: verif/comparator_vref_control_assertions.sv
`timescale 1ns/10ps
module cvc_checker (
  input wire       core_clk,
  input wire       nrst,
  input wire [1:0] addr,
  input wire       wr_stb,
  input wire       rd_stb,
  input wire [7:0] rdata,
  input wire       cmp1_raw,
  input wire       porta_pin2_direction,
  input wire       cmp1_pin,
  input wire [2:0] cmp_mode_sel,
  input wire       cmp1_neg_an3,
  input wire       cmp2_neg_an2,
  input wire       ladder_power_on,
  input wire       ladder_supply_sel,
  input wire       ladder_range_sel,
  input wire [3:0] ladder_level_code,
  input wire       an2_ladder_connect,
  input wire       an2_pin_input,
  input wire [5:0] ladder_tap_num,
  input wire [5:0] ladder_tap_den
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_swap; cmp1_neg_an3 |-> cmp_mode_sel == 3'h6; endproperty
  a_swap: assert property (p_swap) else $error("swap outside mode");
  property p_pair; cmp1_neg_an3 == cmp2_neg_an2; endproperty
  a_pair: assert property (p_pair) else $error("swap pair");
  property p_an2; $past(nrst) |-> an2_pin_input == ($past(porta_pin2_direction) & ~an2_ladder_connect); endproperty
  a_an2: assert property (p_an2) else $error("pin override");
  property p_den; ladder_tap_den == ($past(ladder_range_sel) ? 6'h18 : 6'h20); endproperty
  a_den: assert property (p_den) else $error("tap den");
  property p_num; ladder_tap_num == {2'h0, $past(ladder_level_code)} + ($past(ladder_range_sel) ? 6'h00 : 6'h08); endproperty
  a_num: assert property (p_num) else $error("tap num");
  property p_pin; $changed($past(cmp1_raw, 3)) && !$past(wr_stb) && !$past(wr_stb, 2) |-> $changed(cmp1_pin); endproperty
  a_pin: assert property (p_pin) else $error("pin lag");
  property p_mode; rd_stb && addr == 2'h0 |=> rdata[2:0] == cmp_mode_sel; endproperty
  a_mode: assert property (p_mode) else $error("mode read");
  property p_lad; rd_stb && addr == 2'h1 |=> rdata == {ladder_power_on, an2_ladder_connect, ladder_range_sel,
    ladder_supply_sel, ladder_level_code}; endproperty
  a_lad: assert property (p_lad) else $error("ladder read");
endmodule

// File: verif/comparator_vref_control_tb.sv
`timescale 1ns/10ps
module comparator_vref_control_tb;
  logic core_clk, nrst, wr_stb, rd_stb, porta_pin2_direction;
  logic [1:0] addr;
  logic [7:0] wdata, v1p, v2p;
  wire [7:0] rdata;
  wire [5:0] ladder_tap_num, ladder_tap_den;
  wire [3:0] ladder_level_code;
  wire [2:0] cmp_mode_sel;
  wire cmp1_raw, cmp2_raw, cmp1_pin, cmp2_pin, cmp1_neg_an3, cmp2_neg_an2, ladder_power_on;
  wire ladder_supply_sel, ladder_range_sel, an2_ladder_connect, an2_pin_input;
  int num_errors = 0;
  int n_checks = 0;
  // direction bit above the written byte
  logic [8:0] rows [6] = '{9'h1C5, 9'h03F, 9'h120, 9'h010, 9'h08F, 9'h1A0};
  analog_cmp_model cm (.vin1_pos(v1p), .vin2_pos(v2p), .vin_neg(8'h20), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw));
  comparator_vref_control uut (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // returns once the tap outputs have caught up
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask
  initial begin
    {nrst, wr_stb, rd_stb, addr, wdata} = '0;
    porta_pin2_direction = 1'b1;
    v1p = 8'h10;
    v2p = 8'h10;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    rd(0, 8'h07);
    rd(1, 8'h00);
    $display("reset values done");
    foreach (rows[i]) begin
      @(posedge core_clk);
      porta_pin2_direction <= rows[i][8];
      wr(1, rows[i][7:0]);
      chk({ladder_power_on, an2_ladder_connect, ladder_range_sel, ladder_supply_sel, ladder_level_code}, rows[i][7:0]);
      chk(ladder_tap_num, rows[i][3:0] + (rows[i][5] ? 8'h00 : 8'h08));
      chk(ladder_tap_den, rows[i][5] ? 8'h18 : 8'h20);
      chk(an2_pin_input, rows[i][8] & ~rows[i][6]);
      rd(1, rows[i][7:0]);
    end
    $display("ladder rows done");
    @(posedge core_clk);
    v1p <= 8'h30;
    rd(2, 8'h00);
    wr(2, 8'hFF);
    rd(1, 8'hA0);
    wr(0, 8'hFE);
    rd(0, 8'hBE);
    chk({6'h00, rdata[7:6]}, 8'h02);
    chk({cmp2_pin, cmp1_pin, cmp1_neg_an3, cmp2_neg_an2}, 8'h0B);
    chk({6'h00, cmp2_pin, cmp1_pin}, 8'h02);
    @(posedge core_clk);
    v2p <= 8'h30;
    wr(0, 8'h0F);
    rd(0, 8'hCF);
    chk({cmp2_pin, cmp1_pin, cmp1_neg_an3, cmp2_neg_an2}, 8'h0C);
    $display("comparator done");
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(0, 8'hC7);
    $display("second reset done");
    conclude;
  end
  initial begin
    #50000;
    num_errors++;
    conclude;
  end
endmodule
bind comparator_vref_control cvc_checker chk_i (.*);
